/* File: core/drss_pkg.sv */
package drss_pkg;

  // Clock and tick timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam longint unsigned HUND_TICK_PS = 64'd10_000_000_000;
  localparam int unsigned HUND_TICK_CYC =
    int'(HUND_TICK_PS / CLK_PERIOD_PS);
  localparam int unsigned HUNDS_PER_TENTH = 10;

  // Register interface
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STOP_SRC = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STOP_TIME = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PON_PROT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_UF_ACTION = 4'h4;
  localparam logic [ADDR_W-1:0] REG_WAKE_DLY = 4'h5;
  localparam logic [ADDR_W-1:0] REG_PL_RESTART = 4'h6;
  localparam logic [ADDR_W-1:0] REG_RESTART_WAIT = 4'h7;
  localparam logic [ADDR_W-1:0] REG_START_DLY = 4'h8;
  localparam logic [ADDR_W-1:0] REG_SLEEP_DLY = 4'h9;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'ha;

  // Control register fields
  localparam int unsigned CTRL_TERM_BIT = 0;
  localparam int unsigned CTRL_VF_BIT = 1;
  localparam int unsigned CTRL_RUN_BIT = 2;

  // Status register fields
  localparam int unsigned STAT_STOPPED_BIT = 8;
  localparam int unsigned STAT_BELOW_BIT = 9;

  // Underfrequency action digits
  localparam logic [3:0] UF_RUN_AT_LIMIT = 4'h0;
  localparam logic [3:0] UF_STOP = 4'h1;
  localparam logic [3:0] UF_SLEEP = 4'h2;
  localparam logic [3:0] UF_COAST = 4'h0;
  localparam logic [3:0] UF_DECEL = 4'h1;

  // Setting limits, in ticks, and the largest underfrequency action code
  localparam logic [DATA_W-1:0] STOP_TIME_MAX = 16'h2710;
  localparam logic [DATA_W-1:0] WAKE_DLY_MAX = 16'h8ca0;
  localparam logic [DATA_W-1:0] START_DLY_MAX = 16'h1770;
  localparam logic [DATA_W-1:0] SLEEP_DLY_MAX = 16'h8ca0;
  localparam logic [DATA_W-1:0] UF_ACTION_MAX = 16'h0012;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0001;
  localparam logic [DATA_W-1:0] STOP_TIME_RST = 16'h0032;
  localparam logic [DATA_W-1:0] RESTART_WAIT_RST = 16'h000a;
  localparam logic [DATA_W-1:0] ZERO_RST = 16'h0000;

  typedef struct packed {
    logic term_chan;
    logic vf_mode;
    logic sw_run;
    logic stop_src_meas;
    logic [DATA_W-1:0] stop_time;
    logic pon_unprotect;
    logic [7:0] uf_action;
    logic [DATA_W-1:0] wake_dly;
    logic pl_restart;
    logic [DATA_W-1:0] restart_wait;
    logic [DATA_W-1:0] start_dly;
    logic [DATA_W-1:0] sleep_dly;
  } drss_cfg_type;

  typedef enum logic [7:0] {
    ST_INIT = 8'h01,
    ST_IDLE = 8'h02,
    ST_PROT = 8'h04,
    ST_RESTART = 8'h08,
    ST_START_DLY = 8'h10,
    ST_RUN = 8'h20,
    ST_SLEEP_DLY = 8'h40,
    ST_HALT = 8'h80
  } drss_state_type;

endpackage

/* File: core/drss_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module drss_tick_gen
  import drss_pkg::*;
#(
  parameter int unsigned HUND_CYC = HUND_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  output logic hund_o,
  output logic tenth_o
);

  if (HUND_CYC < 2) begin : g_chk
    $error("HUND_CYC must be at least 2");
  end

  logic [31:0] cyc_q;
  logic [3:0] hund_cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Hundredth-second divider
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_q <= 32'h0;
      hund_o <= 1'b0;
    end else if (cyc_q == 32'(HUND_CYC - 1)) begin
      cyc_q <= 32'h0;
      hund_o <= 1'b1;
    end else begin
      cyc_q <= cyc_q + 32'h1;
      hund_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tenth-second divider
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hund_cnt_q <= 4'h0;
      tenth_o <= 1'b0;
    end else if (hund_o && hund_cnt_q == 4'(HUNDS_PER_TENTH - 1)) begin
      hund_cnt_q <= 4'h0;
      tenth_o <= 1'b1;
    end else begin
      if (hund_o) begin
        hund_cnt_q <= hund_cnt_q + 4'h1;
      end
      tenth_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: core/drss_sequencer.sv */
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module drss_sequencer
  import drss_pkg::*;
#(
  parameter int unsigned HUND_CYC = HUND_TICK_CYC
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DATA_W-1:0] RDATA_O,
  input wire logic RUN_TERM_I,
  input wire logic INIT_DONE_I,
  input wire logic [DATA_W-1:0] SET_FREQ_I,
  input wire logic [DATA_W-1:0] LOWER_LIMIT_I,
  input wire logic [DATA_W-1:0] CMD_SPEED_I,
  input wire logic [DATA_W-1:0] MEAS_SPEED_I,
  input wire logic [DATA_W-1:0] STOP_SPEED_I,
  output logic RUN_O,
  output logic AT_LIMIT_O,
  output logic COAST_O,
  output logic DECEL_O,
  output logic SLEEP_O,
  output logic PROTECT_O,
  output logic STOPPED_O
);

  function automatic logic reached(input logic [DATA_W-1:0] cnt,
                                   input logic [DATA_W-1:0] lim);
    reached = (cnt >= lim);
  endfunction

  function automatic logic [DATA_W-1:0] inc_sat(
      input logic [DATA_W-1:0] cnt);
    inc_sat = (&cnt) ? cnt : cnt + 16'h1;
  endfunction

  drss_cfg_type cfg_q;
  drss_state_type state_q, state_d;
  logic [2:0] term_sync_q;
  logic term_q;
  logic pwr_run_q;
  logic hund_tick, tenth_tick;
  logic [DATA_W-1:0] tmr_q, wake_q, stop_tmr_q;
  logic run_req, below, stop_cond;
  logic [3:0] uf_low, uf_high;
  logic [DATA_W-1:0] wake_target;

  drss_tick_gen #(
    .HUND_CYC(HUND_CYC)
  ) u_tick (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .hund_o(hund_tick),
    .tenth_o(tenth_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Run terminal synchroniser
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      term_sync_q <= 3'h0;
      term_q <= 1'b0;
    end else begin
      term_sync_q <= {term_sync_q[1:0], RUN_TERM_I};
      if (term_sync_q[1] == term_sync_q[2]) begin
        term_q <= term_sync_q[2];
      end
    end
  end

  // Power-up sample of the run terminal
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pwr_run_q <= 1'b0;
    end else if (state_q == ST_INIT) begin
      pwr_run_q <= cfg_q.term_chan && term_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_q.term_chan <= CTRL_RST[CTRL_TERM_BIT];
      cfg_q.vf_mode <= CTRL_RST[CTRL_VF_BIT];
      cfg_q.sw_run <= CTRL_RST[CTRL_RUN_BIT];
      cfg_q.stop_src_meas <= 1'b0;
      cfg_q.stop_time <= STOP_TIME_RST;
      cfg_q.pon_unprotect <= 1'b0;
      cfg_q.uf_action <= ZERO_RST[7:0];
      cfg_q.wake_dly <= ZERO_RST;
      cfg_q.pl_restart <= 1'b0;
      cfg_q.restart_wait <= RESTART_WAIT_RST;
      cfg_q.start_dly <= ZERO_RST;
      cfg_q.sleep_dly <= ZERO_RST;
    end else if (WR_I) begin
      unique case (ADDR_I)
        REG_CTRL: begin
          cfg_q.term_chan <= WDATA_I[CTRL_TERM_BIT];
          cfg_q.vf_mode <= WDATA_I[CTRL_VF_BIT];
          cfg_q.sw_run <= WDATA_I[CTRL_RUN_BIT];
        end
        REG_STOP_SRC: cfg_q.stop_src_meas <= WDATA_I[0];
        REG_STOP_TIME: begin
          if (WDATA_I <= STOP_TIME_MAX) begin
            cfg_q.stop_time <= WDATA_I;
          end
        end
        REG_PON_PROT: cfg_q.pon_unprotect <= WDATA_I[0];
        REG_UF_ACTION: begin
          if (WDATA_I <= UF_ACTION_MAX && WDATA_I[3:0] <= UF_SLEEP) begin
            cfg_q.uf_action <= WDATA_I[7:0];
          end
        end
        REG_WAKE_DLY: begin
          if (WDATA_I <= WAKE_DLY_MAX) begin
            cfg_q.wake_dly <= WDATA_I;
          end
        end
        REG_PL_RESTART: cfg_q.pl_restart <= WDATA_I[0];
        REG_RESTART_WAIT: cfg_q.restart_wait <= WDATA_I;
        REG_START_DLY: begin
          if (WDATA_I <= START_DLY_MAX) begin
            cfg_q.start_dly <= WDATA_I;
          end
        end
        REG_SLEEP_DLY: begin
          if (WDATA_I <= SLEEP_DLY_MAX) begin
            cfg_q.sleep_dly <= WDATA_I;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= ZERO_RST;
    end else if (RD_I) begin
      unique case (ADDR_I)
        REG_CTRL: RDATA_O <= {13'h0, cfg_q.sw_run, cfg_q.vf_mode,
                              cfg_q.term_chan};
        REG_STOP_SRC: RDATA_O <= {15'h0, cfg_q.stop_src_meas};
        REG_STOP_TIME: RDATA_O <= cfg_q.stop_time;
        REG_PON_PROT: RDATA_O <= {15'h0, cfg_q.pon_unprotect};
        REG_UF_ACTION: RDATA_O <= {8'h0, cfg_q.uf_action};
        REG_WAKE_DLY: RDATA_O <= cfg_q.wake_dly;
        REG_PL_RESTART: RDATA_O <= {15'h0, cfg_q.pl_restart};
        REG_RESTART_WAIT: RDATA_O <= cfg_q.restart_wait;
        REG_START_DLY: RDATA_O <= cfg_q.start_dly;
        REG_SLEEP_DLY: RDATA_O <= cfg_q.sleep_dly;
        REG_STATUS: RDATA_O <= {6'h0, below, STOPPED_O, state_q};
        default: RDATA_O <= ZERO_RST;
      endcase
    end else begin
      RDATA_O <= ZERO_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conditions
  assign run_req = cfg_q.term_chan ? term_q : cfg_q.sw_run;
  assign below = (LOWER_LIMIT_I != ZERO_RST) &&
                 (SET_FREQ_I < LOWER_LIMIT_I);
  assign uf_low = cfg_q.uf_action[3:0];
  assign uf_high = cfg_q.uf_action[7:4];
  assign wake_target = (uf_low == UF_SLEEP) ? cfg_q.wake_dly
                                            : ZERO_RST;
  assign stop_cond = (cfg_q.stop_src_meas && !cfg_q.vf_mode) ?
                     (MEAS_SPEED_I <= STOP_SPEED_I) :
                     (CMD_SPEED_I <= STOP_SPEED_I);

  ////////////////////////////////////////////////////////////////////////
  // Stop speed detection
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      stop_tmr_q <= ZERO_RST;
      STOPPED_O <= 1'b0;
    end else if (!stop_cond) begin
      stop_tmr_q <= ZERO_RST;
      STOPPED_O <= 1'b0;
    end else begin
      if (hund_tick) begin
        stop_tmr_q <= inc_sat(stop_tmr_q);
      end
      STOPPED_O <= reached(stop_tmr_q, cfg_q.stop_time);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_INIT: begin
        if (INIT_DONE_I) begin
          if (!pwr_run_q) begin
            state_d = ST_IDLE;
          end else if (cfg_q.pl_restart) begin
            state_d = ST_RESTART;
          end else if (!cfg_q.pon_unprotect) begin
            state_d = ST_PROT;
          end else begin
            state_d = ST_START_DLY;
          end
        end
      end
      ST_IDLE: begin
        if (run_req) begin
          state_d = ST_START_DLY;
        end
      end
      ST_PROT: begin
        if (!run_req) begin
          state_d = ST_IDLE;
        end
      end
      ST_RESTART: begin
        if (!run_req) begin
          state_d = ST_IDLE;
        end else if (reached(tmr_q, cfg_q.restart_wait)) begin
          state_d = ST_START_DLY;
        end
      end
      ST_START_DLY: begin
        if (!run_req) begin
          state_d = ST_IDLE;
        end else if (reached(tmr_q, cfg_q.start_dly)) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!run_req) begin
          state_d = ST_IDLE;
        end else if (below && uf_low == UF_STOP) begin
          state_d = ST_HALT;
        end else if (below && uf_low == UF_SLEEP) begin
          state_d = ST_SLEEP_DLY;
        end
      end
      ST_SLEEP_DLY: begin
        if (!run_req) begin
          state_d = ST_IDLE;
        end else if (!below) begin
          state_d = ST_RUN;
        end else if (reached(tmr_q, cfg_q.sleep_dly)) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (!run_req) begin
          state_d = ST_IDLE;
        end else if (!below && reached(wake_q, wake_target)) begin
          state_d = ST_START_DLY;
        end
      end
      default: state_d = ST_INIT;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Shared state timer, tenth-second ticks
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tmr_q <= ZERO_RST;
    end else if (state_d != state_q) begin
      tmr_q <= ZERO_RST;
    end else if (tenth_tick) begin
      tmr_q <= inc_sat(tmr_q);
    end
  end

  // Accumulated above-limit time while halted
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wake_q <= ZERO_RST;
    end else if (state_q != ST_HALT) begin
      wake_q <= ZERO_RST;
    end else if (tenth_tick && !below) begin
      wake_q <= inc_sat(wake_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RUN_O <= 1'b0;
      AT_LIMIT_O <= 1'b0;
      COAST_O <= 1'b0;
      DECEL_O <= 1'b0;
      SLEEP_O <= 1'b0;
      PROTECT_O <= 1'b0;
    end else begin
      RUN_O <= (state_d == ST_RUN) || (state_d == ST_SLEEP_DLY);
      AT_LIMIT_O <= (state_d == ST_RUN) && below &&
                    (uf_low == UF_RUN_AT_LIMIT);
      COAST_O <= (state_d == ST_HALT) && (uf_high == UF_COAST);
      DECEL_O <= (state_d == ST_HALT) && (uf_high == UF_DECEL);
      SLEEP_O <= (state_d == ST_HALT) && (uf_low == UF_SLEEP);
      PROTECT_O <= (state_d == ST_PROT);
    end
  end

endmodule
`default_nettype wire

/* File: verification/drss_sequencer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module drss_sequencer_asserts
  import drss_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  input wire logic RUN_TERM_I,
  input wire logic INIT_DONE_I,
  input wire logic [DATA_W-1:0] SET_FREQ_I,
  input wire logic [DATA_W-1:0] LOWER_LIMIT_I,
  input wire logic RUN_O,
  input wire logic AT_LIMIT_O,
  input wire logic COAST_O,
  input wire logic DECEL_O,
  input wire logic SLEEP_O,
  input wire logic PROTECT_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == '0)
    else $error("read data not zero outside read slot");

  ////////////////////////////////////////////////////////////////////////
  // Halt and run outputs
  halt_excl_a: assert property (!(COAST_O && DECEL_O))
    else $error("coast and decel both active");
  run_halt_a: assert property (
    RUN_O |-> !(COAST_O || DECEL_O || SLEEP_O))
    else $error("running while halted");
  sleep_halt_a: assert property (SLEEP_O |-> (COAST_O || DECEL_O))
    else $error("sleep without a halt mode");
  limit_run_a: assert property (AT_LIMIT_O |-> RUN_O)
    else $error("limit running without output");
  halt_hold_a: assert property (
    (COAST_O || DECEL_O) && SET_FREQ_I < LOWER_LIMIT_I |=> !RUN_O)
    else $error("woke while set frequency below limit");

  ////////////////////////////////////////////////////////////////////////
  // Power-up protection
  prot_norun_a: assert property (PROTECT_O |-> !RUN_O)
    else $error("running while protected");
  init_norun_a: assert property (
    !INIT_DONE_I |-> !RUN_O && !PROTECT_O)
    else $error("left init before init done");
  prot_hold_a: assert property (
    RUN_TERM_I [*8] ##0 PROTECT_O |=> PROTECT_O)
    else $error("protection left while terminal held");

  c_run: cover property ($rose(RUN_O));
  c_prot: cover property ($rose(PROTECT_O));
  c_sleep: cover property ($rose(SLEEP_O));
  c_limit: cover property ($rose(AT_LIMIT_O));
endmodule

bind drss_sequencer drss_sequencer_asserts drss_sequencer_asserts_inst (
  .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .RUN_TERM_I(RUN_TERM_I), .INIT_DONE_I(INIT_DONE_I),
  .SET_FREQ_I(SET_FREQ_I), .LOWER_LIMIT_I(LOWER_LIMIT_I),
  .RUN_O(RUN_O), .AT_LIMIT_O(AT_LIMIT_O), .COAST_O(COAST_O),
  .DECEL_O(DECEL_O), .SLEEP_O(SLEEP_O), .PROTECT_O(PROTECT_O)
);
`default_nettype wire

/* File: verification/drss_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drss_src_model (
  input wire logic clk_i,
  input wire logic term_i,
  input wire logic [15:0] freq_i,
  output logic run_term_o,
  output logic [15:0] set_freq_o
);
  // Terminal level and setpoint change just after a rising edge
  initial begin
    run_term_o = 1'b0;
    set_freq_o = 16'h0000;
  end
  always @(posedge clk_i) begin
    run_term_o <= term_i;
    set_freq_o <= freq_i;
  end
endmodule
`default_nettype wire

/* File: verification/drss_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module drss_sequencer_tb;
  import drss_pkg::*;
  logic MCLK_I, RST_B_I, WR_I, RD_I, INIT_DONE_I, RUN_TERM_I, term;
  logic [ADDR_W-1:0] ADDR_I;
  logic [DATA_W-1:0] WDATA_I, RDATA_O, SET_FREQ_I, LOWER_LIMIT_I, freq;
  logic [DATA_W-1:0] CMD_SPEED_I, MEAS_SPEED_I, STOP_SPEED_I;
  logic RUN_O, AT_LIMIT_O, COAST_O, DECEL_O, SLEEP_O, PROTECT_O, STOPPED_O;
  logic [6:0] outs_s;
  int bad_count = 0;
  int n_checks = 0;
  logic [15:0] rv [10] = '{CTRL_RST, ZERO_RST, STOP_TIME_RST, ZERO_RST,
    ZERO_RST, ZERO_RST, ZERO_RST, RESTART_WAIT_RST, ZERO_RST, ZERO_RST};
  logic [3:0] ra [6] = '{REG_STOP_TIME, REG_UF_ACTION, REG_UF_ACTION,
    REG_WAKE_DLY, REG_START_DLY, REG_SLEEP_DLY};
  logic [15:0] rb [6] = '{16'h2711, 16'h0013, 16'h0003, 16'h8ca1,
    16'h1771, 16'h8ca1};
  logic [15:0] rm [6] = '{STOP_TIME_MAX, UF_ACTION_MAX, 16'h0002,
    WAKE_DLY_MAX, START_DLY_MAX, SLEEP_DLY_MAX};
  logic [7:0] acts [3] = '{8'h00, 8'h01, 8'h11};
  int bits [3] = '{5, 4, 3};

  drss_sequencer #(.HUND_CYC(10)) drss_sequencer_inst (
    .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .RUN_TERM_I(RUN_TERM_I), .INIT_DONE_I(INIT_DONE_I),
    .SET_FREQ_I(SET_FREQ_I), .LOWER_LIMIT_I(LOWER_LIMIT_I),
    .CMD_SPEED_I(CMD_SPEED_I), .MEAS_SPEED_I(MEAS_SPEED_I),
    .STOP_SPEED_I(STOP_SPEED_I), .RUN_O(RUN_O), .AT_LIMIT_O(AT_LIMIT_O),
    .COAST_O(COAST_O), .DECEL_O(DECEL_O), .SLEEP_O(SLEEP_O),
    .PROTECT_O(PROTECT_O), .STOPPED_O(STOPPED_O));
  drss_src_model drss_src_model_inst (.clk_i(MCLK_I), .term_i(term),
    .freq_i(freq), .run_term_o(RUN_TERM_I), .set_freq_o(SET_FREQ_I));

  ////////////////////////////////////////////////////////////////////////
  // Clock and settled output sample
  initial begin
    MCLK_I = 1'b0;
    forever #4 MCLK_I = ~MCLK_I;
  end
  always @(negedge MCLK_I) begin
    outs_s <= {RUN_O, AT_LIMIT_O, COAST_O, DECEL_O, SLEEP_O, PROTECT_O,
      STOPPED_O};
  end

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge MCLK_I);
  endtask
  task automatic ck(int b, logic v);
    chk($sformatf("out%0d", b), 16'(v), 16'(outs_s[b]));
  endtask
  task automatic wait_out(int b, logic v, int lim);
    for (int i = 0; i < lim && outs_s[b] !== v; i++) @(posedge MCLK_I);
    ck(b, v);
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge MCLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge MCLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    @(posedge MCLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge MCLK_I);
    RD_I <= 1'b0;
    #1;
    chk($sformatf("reg%0h", a), exp, RDATA_O);
  endtask
  task automatic rst(logic t);
    @(posedge MCLK_I);
    RST_B_I <= 1'b0;
    INIT_DONE_I <= 1'b0;
    term <= t;
    cyc(6);
    RST_B_I <= 1'b1;
  endtask
  task automatic pwr(logic t, logic [15:0] pon, logic [15:0] pl,
                     logic [15:0] rw);
    rst(t);
    wr(REG_PON_PROT, pon);
    wr(REG_PL_RESTART, pl);
    wr(REG_RESTART_WAIT, rw);
    INIT_DONE_I <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    cyc(20000);
    bad_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    RST_B_I = 1'b0;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = 4'h0;
    WDATA_I = 16'h0000;
    INIT_DONE_I = 1'b0;
    term = 1'b0;
    freq = 16'h00c8;
    LOWER_LIMIT_I = 16'h0064;
    CMD_SPEED_I = 16'h01f4;
    MEAS_SPEED_I = 16'h01f4;
    STOP_SPEED_I = 16'h000a;
    rst(1'b0);
    for (int i = 0; i < 10; i++) rd(4'(i), rv[i]);
    wr(4'hb, 16'h1234);
    rd(4'hb, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], rb[i]);
      rd(ra[i], rv[ra[i]]);
      wr(ra[i], rm[i]);
      rd(ra[i], rm[i]);
      wr(ra[i], rv[ra[i]]);
    end
    $display("test registers done");
    pwr(1'b1, 16'h0000, 16'h0000, 16'h000a);
    cyc(30);
    ck(6, 1'b0);
    ck(1, 1'b1);
    term <= 1'b0;
    wait_out(1, 1'b0, 20);
    ck(6, 1'b0);
    term <= 1'b1;
    wait_out(6, 1'b1, 20);
    $display("test protection done");
    pwr(1'b1, 16'h0001, 16'h0000, 16'h000a);
    wait_out(6, 1'b1, 30);
    ck(1, 1'b0);
    $display("test unprotected done");
    pwr(1'b1, 16'h0000, 16'h0001, 16'h0002);
    cyc(150);
    ck(6, 1'b0);
    ck(1, 1'b0);
    wait_out(6, 1'b1, 200);
    $display("test restart done");
    wr(REG_SLEEP_DLY, 16'h0001);
    wr(REG_WAKE_DLY, 16'h0002);
    wr(REG_START_DLY, 16'h0001);
    wr(REG_UF_ACTION, 16'h0002);
    freq <= 16'h0032;
    cyc(50);
    ck(6, 1'b1);
    wait_out(2, 1'b1, 150);
    ck(4, 1'b1);
    freq <= 16'h00c8;
    cyc(120);
    freq <= 16'h0032;
    cyc(50);
    ck(2, 1'b1);
    freq <= 16'h00c8;
    cyc(50);
    ck(6, 1'b0);
    ck(2, 1'b0);
    cyc(40);
    ck(6, 1'b0);
    wait_out(6, 1'b1, 250);
    $display("test sleep done");
    wr(REG_START_DLY, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(REG_UF_ACTION, {8'h00, acts[i]});
      freq <= 16'h0032;
      wait_out(bits[i], 1'b1, 20);
      ck(6, acts[i] == 8'h00);
      freq <= 16'h00c8;
      wait_out(6, 1'b1, 20);
      wait_out(bits[i], 1'b0, 20);
    end
    $display("test underfrequency done");
    term <= 1'b0;
    wait_out(6, 1'b0, 20);
    wr(REG_STOP_TIME, 16'h0005);
    CMD_SPEED_I <= 16'h0000;
    cyc(30);
    ck(0, 1'b0);
    cyc(50);
    ck(0, 1'b1);
    wr(REG_STOP_SRC, 16'h0001);
    wait_out(0, 1'b0, 20);
    wr(REG_CTRL, 16'h0003);
    wait_out(0, 1'b1, 80);
    rd(REG_STATUS, 16'h0102);
    $display("test stop detection done");
    stop_test();
  end
endmodule
`default_nettype wire
